// [include/acrc_consts.svh]
`ifndef ACRC_CONSTS_SVH
`define ACRC_CONSTS_SVH

// Register byte offsets
`define ACRC_OFS_CHAN 8'h00
`define ACRC_OFS_CLK 8'h04
`define ACRC_OFS_RESH 8'h08
`define ACRC_OFS_RESL 8'h0C
`define ACRC_OFS_STAT 8'h10
`define ACRC_OFS_MASK 8'h14

// Field positions
`define ACRC_BIT_PWR 0
`define ACRC_BIT_GO 1
`define ACRC_CHS_LSB 2
`define ACRC_CHS_MSB 6
`define ACRC_CS_LSB 4
`define ACRC_CS_MSB 6
`define ACRC_BIT_DONE 0
`define ACRC_LANE0 0

// Conversion clock select codes
`define ACRC_CS_DIV8 3'b001
`define ACRC_CS_DIV16 3'b101
`define ACRC_CS_DIV32 3'b010
`define ACRC_CS_DIV64 3'b110
`define ACRC_CS_RC_LOW 2'b11

// Divisors in system clock cycles
`define ACRC_DIV_8 7'h08
`define ACRC_DIV_16 7'h10
`define ACRC_DIV_32 7'h20
`define ACRC_DIV_64 7'h40
`define ACRC_DIV_RC 7'h10
`define ACRC_DIV_NONE 7'h00
`define ACRC_DIV_ONE 7'h01

// Bus responses
`define ACRC_RESP_OKAY 2'b00
`define ACRC_RESP_SLVERR 2'b10

// Approximation bit indices
`define ACRC_SAR_MSB 4'h9
`define ACRC_SAR_LSB 4'h0
`define ACRC_SAR_ONE 4'h1

`endif

// [include/acrc_pkg.sv]
`default_nettype none
package acrc_pkg;
    typedef logic [9:0] acrc_result_t;
    typedef logic [2:0] acrc_clk_sel_t;
    typedef logic [6:0] acrc_div_t;
    typedef enum logic [0:0] {
        ACRC_ST_IDLE = 1'b0,
        ACRC_ST_CONVERT = 1'b1
    } acrc_sar_state_e;
endpackage
`default_nettype wire

// [include/acrc_conv_if.sv]
`default_nettype none
interface acrc_conv_if;
    import acrc_pkg::*;
    logic start;
    logic abort;
    logic tick;
    acrc_result_t sample;
    logic busy;
    logic done;
    acrc_result_t result;
    modport ctrl (output start, abort, tick, sample, input busy, done, result);
    modport sar (input start, abort, tick, sample, output busy, done, result);
endinterface
`default_nettype wire

// [core/acrc_sar.sv]
`include "acrc_consts.svh"
`default_nettype none
module acrc_sar
    import acrc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Conversion link
    acrc_conv_if.sar conv
);
    acrc_sar_state_e state_reg;
    acrc_result_t held_reg;
    acrc_result_t trial_reg;
    acrc_result_t result_reg;
    acrc_result_t decided;
    logic [3:0] bit_reg;
    logic done_reg;
    logic last_step;

    function automatic acrc_result_t bit_mask(input logic [3:0] idx);
        bit_mask = acrc_result_t'(1) << idx;
    endfunction

    assign last_step = conv.tick && (bit_reg == `ACRC_SAR_LSB);
    // Keep the trial bit only while the trial stays at or below the held level
    assign decided = (trial_reg <= held_reg) ? trial_reg : (trial_reg & ~bit_mask(bit_reg));
    assign conv.busy = (state_reg == ACRC_ST_CONVERT);
    assign conv.done = done_reg;
    assign conv.result = result_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ACRC_ST_IDLE;
        end else if (conv.abort) begin
            state_reg <= ACRC_ST_IDLE;
        end else begin
            unique case (state_reg)
                ACRC_ST_IDLE: if (conv.start) state_reg <= ACRC_ST_CONVERT;
                ACRC_ST_CONVERT: if (last_step) state_reg <= ACRC_ST_IDLE;
            endcase
        end
    end

    // Level frozen at start, so the input may move during conversion
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            held_reg <= '0;
            trial_reg <= '0;
            bit_reg <= `ACRC_SAR_MSB;
        end else if (conv.start && state_reg == ACRC_ST_IDLE) begin
            held_reg <= conv.sample;
            trial_reg <= bit_mask(`ACRC_SAR_MSB);
            bit_reg <= `ACRC_SAR_MSB;
        end else if (conv.busy && conv.tick && !last_step) begin
            trial_reg <= decided | bit_mask(bit_reg - `ACRC_SAR_ONE);
            bit_reg <= bit_reg - `ACRC_SAR_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= conv.busy && last_step && !conv.abort;
            if (conv.busy && last_step && !conv.abort) begin
                result_reg <= decided;
            end
        end
    end

    property p_sar_exact;
        @(posedge clk_i) disable iff (!rst_n_i)
        conv.done |-> conv.result == held_reg;
    endproperty
    a_sar_exact: assert property (p_sar_exact)
        else $error("Result differs from held level");
endmodule
`default_nettype wire

// [core/acrc_top.sv]
// Function
// - Clock select 010 gives /32, 101 gives /16, 110 gives /64, 001 gives /8.
// - Clock select x11 runs from internal oscillator /16; 000 and 100 reserved.
// - Clock control bit 7 and bits 3..0 always read zero.
// - Result high bits 1..0 hold result bits 9..8.
// - Result high bits 7..2 read zero; result registers are read-only.
// - Result low bits 7..0 hold result bits 7..0.
// - Each conversion yields a ten-bit unsigned value, 1024 levels.
// - Setting the status bit starts a conversion; it reads one while busy.
// - Hardware clears the status bit when conversion finishes.
// - Power bit zero disables the converter; one enables it.
// - Five-bit channel field routes one analog source to the converter.
`include "acrc_consts.svh"
`default_nettype none
module acrc_top
    import acrc_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // Analog side
    input wire logic [9:0] ANALOG_LEVEL_I,
    output logic [4:0] CHANNEL_SEL_O,
    output logic CONV_POWER_ON_O,
    // Interrupt
    output logic IRQ_O
);
    logic rst_s1;
    logic rst_n;
    acrc_result_t samp_s1;
    acrc_result_t samp_s2;
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] rd_addr_reg;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic wr_fire;
    logic wr_chan;
    logic wr_clk;
    logic wr_stat;
    logic wr_mask;
    logic [4:0] chan_reg;
    logic go_reg;
    logic pwr_reg;
    acrc_clk_sel_t clk_sel_reg;
    acrc_result_t result_reg;
    logic stat_reg;
    logic mask_reg;
    acrc_div_t div_cnt_reg;
    acrc_div_t div_now;
    logic tick;
    logic start;
    logic abort;

    acrc_conv_if conv ();

    acrc_sar u_sar (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .conv(conv)
    );

    // Reserved codes give no divisor, so a conversion never advances
    function automatic acrc_div_t div_of(input acrc_clk_sel_t sel);
        if (sel[1:0] == `ACRC_CS_RC_LOW) begin
            div_of = `ACRC_DIV_RC;
        end else begin
            unique case (sel)
                `ACRC_CS_DIV8: div_of = `ACRC_DIV_8;
                `ACRC_CS_DIV16: div_of = `ACRC_DIV_16;
                `ACRC_CS_DIV32: div_of = `ACRC_DIV_32;
                `ACRC_CS_DIV64: div_of = `ACRC_DIV_64;
                default: div_of = `ACRC_DIV_NONE;
            endcase
        end
    endfunction

    // Reset release through two flops
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Analog level comes from outside the clock domain
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            samp_s1 <= '0;
            samp_s2 <= '0;
        end else begin
            samp_s1 <= ANALOG_LEVEL_I;
            samp_s2 <= samp_s1;
        end
    end

    assign S_AXI_AWREADY_O = !aw_full_reg;
    assign S_AXI_WREADY_O = !w_full_reg;
    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O = bresp_reg;
    assign S_AXI_ARREADY_O = !rvalid_reg;
    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RRESP_O = rresp_reg;
    assign S_AXI_RDATA_O = rdata_reg;
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;

    // Address and data may arrive in either order
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (S_AXI_AWVALID_I && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR_I;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            w_full_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (S_AXI_WVALID_I && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA_I;
            wstrb_reg <= S_AXI_WSTRB_I;
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    always_comb begin
        unique case (aw_addr_reg)
            `ACRC_OFS_CHAN, `ACRC_OFS_CLK, `ACRC_OFS_RESH,
            `ACRC_OFS_RESL, `ACRC_OFS_STAT, `ACRC_OFS_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Only byte lane 0 carries register bits
    assign wr_chan = wr_fire && wstrb_reg[`ACRC_LANE0] && aw_addr_reg == `ACRC_OFS_CHAN;
    assign wr_clk = wr_fire && wstrb_reg[`ACRC_LANE0] && aw_addr_reg == `ACRC_OFS_CLK;
    assign wr_stat = wr_fire && wstrb_reg[`ACRC_LANE0] && aw_addr_reg == `ACRC_OFS_STAT;
    assign wr_mask = wr_fire && wstrb_reg[`ACRC_LANE0] && aw_addr_reg == `ACRC_OFS_MASK;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `ACRC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `ACRC_RESP_OKAY : `ACRC_RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR_I)
            `ACRC_OFS_CHAN: rd_word = {24'h000000, 1'b0, chan_reg, go_reg, pwr_reg};
            `ACRC_OFS_CLK: rd_word = {24'h000000, 1'b0, clk_sel_reg, 4'h0};
            `ACRC_OFS_RESH: rd_word = {30'h0, result_reg[9:8]};
            `ACRC_OFS_RESL: rd_word = {24'h000000, result_reg[7:0]};
            `ACRC_OFS_STAT: rd_word = {31'h00000000, stat_reg};
            `ACRC_OFS_MASK: rd_word = {31'h00000000, mask_reg};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `ACRC_RESP_OKAY;
            rdata_reg <= '0;
            rd_addr_reg <= '0;
        end else if (S_AXI_ARVALID_I && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? `ACRC_RESP_OKAY : `ACRC_RESP_SLVERR;
            rdata_reg <= rd_word;
            rd_addr_reg <= S_AXI_ARADDR_I;
        end else if (S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
        end
    end

    // A start needs power on in the same write and no conversion running
    assign start = wr_chan && wdata_reg[`ACRC_BIT_GO] && wdata_reg[`ACRC_BIT_PWR] && !go_reg;
    assign abort = wr_chan && !wdata_reg[`ACRC_BIT_PWR];

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= 1'b0;
            chan_reg <= '0;
            clk_sel_reg <= '0;
        end else begin
            if (wr_chan) begin
                pwr_reg <= wdata_reg[`ACRC_BIT_PWR];
                chan_reg <= wdata_reg[`ACRC_CHS_MSB:`ACRC_CHS_LSB];
            end
            if (wr_clk) begin
                clk_sel_reg <= wdata_reg[`ACRC_CS_MSB:`ACRC_CS_LSB];
            end
        end
    end

    // Writing zero to the busy bit does not abort; only power off does
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            go_reg <= 1'b0;
        end else if (conv.done || abort) begin
            go_reg <= 1'b0;
        end else if (start) begin
            go_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= '0;
        end else if (conv.done) begin
            result_reg <= conv.result;
        end
    end

    // Flag set wins over a same-cycle clear
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= 1'b0;
            mask_reg <= 1'b0;
        end else begin
            stat_reg <= (stat_reg && !(wr_stat && wdata_reg[`ACRC_BIT_DONE])) || conv.done;
            if (wr_mask) begin
                mask_reg <= wdata_reg[`ACRC_BIT_DONE];
            end
        end
    end

    // Divider restarts with each conversion so the first step is a full period
    assign div_now = div_of(clk_sel_reg);
    assign tick = go_reg && div_now != `ACRC_DIV_NONE && div_cnt_reg == div_now - `ACRC_DIV_ONE;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= '0;
        end else if (!go_reg || start || tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + `ACRC_DIV_ONE;
        end
    end

    assign conv.start = start;
    assign conv.abort = abort;
    assign conv.tick = tick;
    assign conv.sample = samp_s2;
    assign CHANNEL_SEL_O = chan_reg;
    assign CONV_POWER_ON_O = pwr_reg;
    assign IRQ_O = stat_reg && mask_reg;

    property p_div8;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        ($rose(go_reg) && clk_sel_reg == `ACRC_CS_DIV8) |-> !tick [*7] ##1 tick;
    endproperty
    a_div8: assert property (p_div8)
        else $error("Divide by 8 step spacing wrong");

    property p_div_rc;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        ($rose(go_reg) && clk_sel_reg[1:0] == `ACRC_CS_RC_LOW) |-> ##15 tick;
    endproperty
    a_div_rc: assert property (p_div_rc)
        else $error("Internal clock step spacing wrong");

    property p_clk_zero;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        (rvalid_reg && rd_addr_reg == `ACRC_OFS_CLK) |-> rdata_reg[7] == 1'b0
            && rdata_reg[3:0] == 4'h0;
    endproperty
    a_clk_zero: assert property (p_clk_zero)
        else $error("Clock control reserved bits not zero");

    property p_res_high;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        ($past(S_AXI_ARVALID_I && !rvalid_reg) && rd_addr_reg == `ACRC_OFS_RESH)
            |-> rdata_reg[31:2] == '0 && rdata_reg[1:0] == $past(result_reg[9:8]);
    endproperty
    a_res_high: assert property (p_res_high)
        else $error("High result read wrong");

    property p_res_low;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        ($past(S_AXI_ARVALID_I && !rvalid_reg) && rd_addr_reg == `ACRC_OFS_RESL)
            |-> rdata_reg == {24'h000000, $past(result_reg[7:0])};
    endproperty
    a_res_low: assert property (p_res_low)
        else $error("Low result read wrong");

    property p_start;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        start |=> go_reg && conv.busy;
    endproperty
    a_start: assert property (p_start)
        else $error("Start did not begin a conversion");

    property p_finish;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        conv.done |=> !go_reg && result_reg == $past(conv.result);
    endproperty
    a_finish: assert property (p_finish)
        else $error("Completion did not clear busy and load result");

    property p_power_off;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        abort |=> !go_reg && !conv.busy && !CONV_POWER_ON_O;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("Power off left converter running");

    property p_channel;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_chan |=> CHANNEL_SEL_O == $past(wdata_reg[`ACRC_CHS_MSB:`ACRC_CHS_LSB]);
    endproperty
    a_channel: assert property (p_channel)
        else $error("Channel select not applied");

    property p_done_irq;
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        conv.done |=> stat_reg && IRQ_O == mask_reg;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("Done flag or interrupt wrong");
endmodule
`default_nettype wire

// [tb/acrc_analog_src.sv]
`default_nettype none
module acrc_analog_src (
    // Clock
    input wire logic clk_i,
    // Selection
    input wire logic [4:0] channel_i,
    input wire logic power_i,
    // Level
    output logic [9:0] level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] churn_reg = 10'h000;
    // Unpowered input floats, so show a moving pattern
    always_ff @(posedge clk_i) begin
        churn_reg <= churn_reg + 10'h1B7;
    end
    assign level_o = power_i ? {channel_i, ~channel_i} : churn_reg;
endmodule
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ACQ_CYC = 100;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, pwr, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [9:0] level;
    wire logic [4:0] chan;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    acrc_top uut (.CLK_SYS_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .ANALOG_LEVEL_I(level), .CHANNEL_SEL_O(chan),
        .CONV_POWER_ON_O(pwr), .IRQ_O(irq));
    acrc_analog_src src (.clk_i(clk), .channel_i(chan), .power_i(pwr), .level_o(level));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Handshakes judged at the falling edge, where the sampled values sit still
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge clk);
            ha = awvalid && (awready === 1'b1);
            hw = wvalid && (wready === 1'b1);
            hb = bvalid === 1'b1;
            r = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge clk);
            ha = arvalid && (arready === 1'b1);
            hr = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hr) rready <= 1'b0;
        end
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axr(8'h00, d, r);
        chk("chan ctrl reset", 32'h0, d);
        chk("read resp okay", 32'h0, {30'h0, r});
        axr(8'h04, d, r);
        chk("clk ctrl reset", 32'h0, d);
        axw(8'h04, 32'h0000_00FF, r);
        chk("write resp okay", 32'h0, {30'h0, r});
        axr(8'h04, d, r);
        chk("clk ctrl unused bits", 32'h70, d);
        axw(8'h00, 32'h0000_00FD, r);
        axr(8'h00, d, r);
        chk("chan ctrl readback", 32'h7D, d);
        chk("channel pins", 32'h1F, {27'h0, chan});
        chk("power pin on", 32'h1, {31'h0, pwr});
        axw(8'h08, 32'h0000_00FF, r);
        axr(8'h08, d, r);
        chk("result high read-only", 32'h0, d);
        axw(8'h18, 32'h1, r);
        chk("unmapped write resp", 32'h2, {30'h0, r});
        axr(8'h18, d, r);
        chk("unmapped read resp", 32'h2, {30'h0, r});
    endtask
    task automatic t_convert(input logic [2:0] cs, input int div, input logic [4:0] ch);
        logic [31:0] d;
        logic [1:0] r;
        logic [9:0] lv;
        int t0;
        int el;
        lv = {ch, ~ch};
        axw(8'h04, {25'h0, cs, 4'h0}, r);
        axw(8'h00, {25'h0, ch, 2'b01}, r);
        repeat (ACQ_CYC) @(posedge clk);
        axw(8'h00, {25'h0, ch, 2'b11}, r);
        t0 = cyc;
        axr(8'h00, d, r);
        chk("busy after start", {25'h0, ch, 2'b11}, d);
        while (d[1] === 1'b1 && cyc - t0 < 1000) axr(8'h00, d, r);
        el = cyc - t0 - 10 * div;
        chk("conversion time", 32'h1, {31'h0, el >= -2 && el <= 8});
        chk("busy cleared", {25'h0, ch, 2'b01}, d);
        axr(8'h08, d, r);
        chk("result high", {30'h0, lv[9:8]}, d);
        axr(8'h0C, d, r);
        chk("result low", {24'h0, lv[7:0]}, d);
        axr(8'h10, d, r);
        chk("done flag set", 32'h1, d);
        axw(8'h10, 32'h1, r);
        axr(8'h10, d, r);
        chk("done flag cleared", 32'h0, d);
    endtask
    task automatic t_irq();
        logic [1:0] r;
        t_convert(3'b001, 8, 5'h0A);
        axw(8'h14, 32'h1, r);
        axw(8'h00, 32'h0000_002B, r);
        repeat (120) @(posedge clk);
        chk("irq enabled", 32'h1, {31'h0, irq});
        axw(8'h14, 32'h0, r);
        chk("irq masked", 32'h0, {31'h0, irq});
        axw(8'h14, 32'h1, r);
        axw(8'h10, 32'h1, r);
        chk("irq after clear", 32'h0, {31'h0, irq});
    endtask
    // Reserved clock codes never finish, so power off is the only way out
    task automatic t_abort();
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] rsv [2] = '{3'b000, 3'b100};
        for (int i = 0; i < 2; i++) begin
            axw(8'h04, {25'h0, rsv[i], 4'h0}, r);
            axw(8'h00, 32'h0000_0011, r);
            repeat (ACQ_CYC) @(posedge clk);
            axw(8'h00, 32'h0000_0013, r);
            repeat (700) @(posedge clk);
            axr(8'h00, d, r);
            chk("reserved code stalls", 32'h13, d);
            axw(8'h00, 32'h0000_0010, r);
            axr(8'h00, d, r);
            chk("abort clears busy", 32'h10, d);
            chk("power pin off", 32'h0, {31'h0, pwr});
            axr(8'h10, d, r);
            chk("no flag on abort", 32'h0, d);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_convert(3'b001, 8, 5'h01);
        t_convert(3'b101, 16, 5'h07);
        t_convert(3'b010, 32, 5'h0D);
        t_convert(3'b110, 64, 5'h13);
        t_convert(3'b011, 16, 5'h19);
        t_convert(3'b111, 16, 5'h1F);
        t_irq();
        t_abort();
        close_out();
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
